// ===== rtl/fcd_pkg.sv
// Shared constants and types of the flash command sequence decoder
package fcd_pkg;
  localparam int AW = 24;
  localparam int DW = 16;
  localparam logic [10:0] UNLOCK_A1 = 11'h555;
  localparam logic [10:0] UNLOCK_A2 = 11'h2aa;
  localparam logic [7:0] C_AA = 8'haa;
  localparam logic [7:0] C_55 = 8'h55;
  localparam logic [7:0] C_EXIT = 8'hf0;
  localparam logic [7:0] C_SR_RD = 8'h70;
  localparam logic [7:0] C_SR_CLR = 8'h71;
  localparam logic [7:0] C_TMR_LD = 8'h34;
  localparam logic [7:0] C_TMR_RD = 8'h3c;
  localparam logic [7:0] C_ICR_LD = 8'h36;
  localparam logic [7:0] C_ISR_LD = 8'h37;
  localparam logic [7:0] C_VCR_LD = 8'h38;
  localparam logic [7:0] C_ICR_RD = 8'hc4;
  localparam logic [7:0] C_ISR_RD = 8'hc5;
  localparam logic [7:0] C_VCR_RD = 8'hc7;
  localparam logic [7:0] C_PROG = 8'ha0;
  localparam logic [7:0] C_ID = 8'h90;
  localparam logic [7:0] C_CFI = 8'h98;
  localparam logic [7:0] C_ERS1 = 8'h80;
  localparam logic [7:0] C_SECT = 8'h30;
  localparam logic [7:0] C_ESUS = 8'hb0;
  localparam logic [7:0] C_ERES = 8'h30;
  localparam logic [7:0] C_PSUS = 8'h51;
  localparam logic [7:0] C_PRES = 8'h50;
  localparam logic [7:0] C_KEY = 8'he8;
  localparam logic [7:0] C_MODE = 8'h40;
  localparam logic [7:0] C_SLK = 8'he0;
  localparam logic [7:0] C_PST = 8'h3a;
  localparam logic [15:0] TMR_RST = 16'h0000;
  localparam logic [15:0] ICR_RST = 16'hffff;
  localparam logic [15:0] ISR_RST = 16'hffff;
  localparam logic [15:0] VCR_RST = 16'h8e8b;
  localparam logic [15:0] MODE_RST = 16'hffff;
  localparam int MODE_PERS = 1;
  localparam int MODE_PWD = 2;
  localparam int FAIL_BIT = 5;
  localparam int SECT_LO = 11;
  localparam int SECT_HI = 16;
  localparam int LINK_DIV = 5;
  // Host frame phases on the link: idle, clocked phase A, then closing phase B
  typedef enum logic [1:0] {
    FCD_IDLE,
    FCD_PHASE_A,
    FCD_PHASE_B
  } fcd_lph_t;
endpackage

// ===== rtl/fcd_if.sv
// Link between host controller and flash decoder
`timescale 1ns/100ps
`default_nettype none
interface fcd_if;
  logic        cs_n;
  logic        bus_clock;
  logic        rw_n;
  logic [23:0] addr;
  logic [7:0]  dq_h;
  logic [15:0] dq_d;
  logic        dq_h_oe_n;
  logic [15:0] dq_f;
  logic        rvalid;
  modport host (output cs_n, output bus_clock, output rw_n, output addr,
    output dq_h, output dq_h_oe_n, input dq_f, input rvalid);
  modport flash (input cs_n, input bus_clock, input rw_n, input addr,
    input dq_h, input dq_d, input dq_h_oe_n, output dq_f, output rvalid);
  assign dq_d = {dq_h, dq_h};
endinterface
`default_nettype wire

// ===== rtl/fcd_flash.sv
// Flash end: command sequence decoder and register set
`timescale 1ns/100ps
`default_nettype none
module fcd_flash
  import fcd_pkg::*;
(
  input  wire logic            i_ref_clk,
  input  wire logic            i_sys_rst,
  input  wire logic            i_ce,
  fcd_if.flash                 lnk,
  input  wire logic [DW-1:0]   i_array_word,
  input  wire logic            i_erasing,
  input  wire logic            i_fail,
  input  wire logic [DW-1:0]   i_sect_lock,
  output logic [AW-1:0]        o_loc,
  output logic [DW-1:0]        o_prog_word,
  output logic                 o_prog_go,
  output logic                 o_erase_go,
  output logic [5:0]           o_param_sect,
  output logic [15:0]          o_timer,
  output logic                 o_esus,
  output logic                 o_psus,
  output logic                 o_id_mode,
  output logic                 o_sr_clr
);
  import fcd_pkg::*;
  typedef enum logic [3:0] {
    S_C1, S_C2, S_C3, S_ARG, S_E4, S_E5, S_E6, S_SR, S_ABORT, S_AB2,
    S_AB3
  } fcd_st_t;
  // Two-stage synchronisers for link pins
  logic [2:0] ck_s_q, cs_s_q;
  logic       ck_p_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ck_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      ck_p_q <= 1'b0;
    end else if (i_ce) begin
      ck_s_q <= {ck_s_q[1:0], lnk.bus_clock};
      cs_s_q <= {cs_s_q[1:0], lnk.cs_n};
      ck_p_q <= ck_s_q[1];
    end
  end
  // Bus data held stable by host across whole frame, still two stages
  logic [AW-1:0] a_s_q, a_q;
  logic [DW-1:0] d_s_q, d_q;
  logic          rw_s_q, rw_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      a_s_q  <= '0;
      d_s_q  <= '0;
      rw_s_q <= 1'b1;
      a_q    <= '0;
      d_q    <= '0;
      rw_q   <= 1'b1;
    end else if (i_ce) begin
      a_s_q  <= lnk.addr;
      d_s_q  <= lnk.dq_d;
      rw_s_q <= lnk.rw_n;
      a_q    <= a_s_q;
      d_q    <= d_s_q;
      rw_q   <= rw_s_q;
    end
  end
  wire rise = ck_s_q[1] & ~ck_p_q & ~cs_s_q[1];
  logic first_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) first_q <= 1'b1;
    else if (i_ce) begin
      if (cs_s_q[1]) first_q <= 1'b1;
      else if (rise) first_q <= 1'b0;
    end
  end
  wire take = rise & first_q;
  wire wr = take & ~rw_q;
  wire rd = take & rw_q;
  wire [7:0] cmd = d_q[7:0];
  wire [10:0] lo = a_q[10:0];
  wire at1 = lo == UNLOCK_A1;
  fcd_st_t st_q;
  logic [7:0] sel_q;
  logic [1:0] key_ix_q;
  logic [15:0] icr_q, isr_q, vcr_q, mode_q;
  logic [DW-1:0] key_q [0:3];
  logic sr_rd_q, id_q, pgm_q;
  // Sequence tracker
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_q  <= S_C1;
      sel_q <= 8'h00;
    end else if (i_ce && wr) begin
      case (st_q)
        S_C1: begin
          if (cmd == C_AA && at1) st_q <= S_C2;
          else if (cmd == C_SR_RD && at1) st_q <= S_SR;
        end
        S_C2: st_q <= (cmd == C_55 && lo == UNLOCK_A2) ? S_C3 : S_C1;
        S_C3: begin
          sel_q <= cmd;
          case (cmd)
            C_TMR_LD, C_ICR_LD, C_ISR_LD, C_VCR_LD, C_PROG:
              st_q <= at1 ? S_ARG : S_C1;
            // Read codes wait for the fourth cycle, a read
            C_TMR_RD, C_ICR_RD, C_ISR_RD, C_VCR_RD:
              st_q <= at1 ? S_ARG : S_C1;
            C_ERS1: st_q <= at1 ? S_E4 : S_C1;
            default: st_q <= S_C1;
          endcase
        end
        S_ARG: st_q <= S_C1;
        S_E4: st_q <= (cmd == C_AA && at1) ? S_E5 : S_C1;
        S_E5: st_q <= (cmd == C_55 && lo == UNLOCK_A2) ? S_E6 : S_C1;
        S_E6: st_q <= S_C1;
        S_SR: st_q <= S_C1;
        // Single F0 is not enough to leave abort
        S_ABORT: st_q <= (cmd == C_AA && at1) ? S_AB2 : S_ABORT;
        S_AB2: st_q <= (cmd == C_55 && lo == UNLOCK_A2) ? S_AB3 : S_ABORT;
        S_AB3: st_q <= (cmd == C_EXIT && at1) ? S_C1 : S_ABORT;
        default: st_q <= S_C1;
      endcase
    end else if (i_ce && rd && (st_q == S_SR || st_q == S_ARG)) begin
      st_q <= S_C1;
    end
  end
  wire arg_wr = wr && st_q == S_ARG;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_timer <= TMR_RST;
      icr_q   <= ICR_RST;
      isr_q   <= ISR_RST;
      vcr_q   <= VCR_RST;
    end else if (i_ce && arg_wr) begin
      if (sel_q == C_TMR_LD) o_timer <= d_q;
      if (sel_q == C_ICR_LD) icr_q <= d_q;
      if (sel_q == C_ISR_LD) isr_q <= d_q;
      if (sel_q == C_VCR_LD) vcr_q <= d_q;
    end
  end
  // Program and erase launch strobes
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_prog_go    <= 1'b0;
      o_erase_go   <= 1'b0;
      o_loc        <= '0;
      o_prog_word  <= '0;
      o_param_sect <= 6'h00;
    end else if (i_ce) begin
      o_prog_go  <= arg_wr && sel_q == C_PROG;
      o_erase_go <= wr && st_q == S_E6 && cmd == C_SECT;
      if (wr && (st_q == S_ARG || st_q == S_E6)) begin
        o_loc        <= a_q;
        o_prog_word  <= d_q;
        o_param_sect <= a_q[SECT_HI:SECT_LO];
      end
    end
  end
  // Single-cycle mode commands, plus ID entry on the third unlocked cycle
  wire one = wr && st_q == S_C1;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_esus    <= 1'b0;
      o_psus    <= 1'b0;
      id_q      <= 1'b0;
      o_sr_clr  <= 1'b0;
      pgm_q     <= 1'b0;
    end else if (i_ce) begin
      o_sr_clr <= one && cmd == C_SR_CLR && at1;
      pgm_q    <= arg_wr && sel_q == C_PROG;
      if (one && cmd == C_ESUS && i_erasing) o_esus <= 1'b1;
      else if (one && cmd == C_ERES && o_esus) o_esus <= 1'b0;
      if (one && cmd == C_PSUS && pgm_q) o_psus <= 1'b1;
      else if (one && cmd == C_PRES && o_psus) o_psus <= 1'b0;
      if (one && cmd == C_CFI && at1 && (!i_erasing || o_esus)) id_q <= 1'b1;
      else if (wr && st_q == S_C3 && cmd == C_ID) id_q <= 1'b1;
      else if (one && cmd == C_EXIT) id_q <= 1'b0;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      key_ix_q <= 2'h0;
      mode_q   <= MODE_RST;
    end else if (i_ce && arg_wr && sel_q == C_PROG && id_q) begin
      key_q[key_ix_q] <= d_q;
      key_ix_q <= key_ix_q + 2'h1;
      if (!(~d_q[MODE_PERS] & ~d_q[MODE_PWD])) mode_q <= mode_q & d_q;
    end
  end
  // Read answer: first word only; later edges in the frame get no answer
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      lnk.dq_f   <= '0;
      lnk.rvalid <= 1'b0;
      sr_rd_q    <= 1'b0;
      o_id_mode  <= 1'b0;
    end else if (i_ce) begin
      o_id_mode  <= id_q;
      lnk.rvalid <= rd;
      sr_rd_q    <= st_q == S_SR;
      if (rd) begin
        if (st_q == S_SR) lnk.dq_f <= {10'h3ff, i_fail, 5'h1f};
        else if (st_q == S_ARG && sel_q == C_TMR_RD) lnk.dq_f <= o_timer;
        else if (st_q == S_ARG && sel_q == C_ICR_RD) lnk.dq_f <= icr_q;
        else if (st_q == S_ARG && sel_q == C_ISR_RD) lnk.dq_f <= isr_q;
        else if (st_q == S_ARG && sel_q == C_VCR_RD) lnk.dq_f <= vcr_q;
        else if (id_q && lo == UNLOCK_A1) lnk.dq_f <= {15'h7fff, i_sect_lock[0]};
        else if (id_q) lnk.dq_f <= {13'h1fff, i_sect_lock[2:0]};
        else lnk.dq_f <= i_array_word;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/fcd_host.sv
// Host end: drives single-word frames on the flash link
`timescale 1ns/100ps
`default_nettype none
module fcd_host
  import fcd_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_ce,
  fcd_if.host                lnk,
  input  wire logic          i_go,
  input  wire logic          i_rd,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_data,
  output logic               o_busy,
  output logic               o_rvalid,
  output logic [DW-1:0]      o_rdata
);
  import fcd_pkg::*;
  // One frame = one bus cycle; long frames hold data steady
  logic [3:0] cnt_q;
  fcd_lph_t ph_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ph_q <= FCD_IDLE;
      cnt_q <= 4'h0;
      lnk.cs_n <= 1'b1;
      lnk.bus_clock <= 1'b0;
      lnk.rw_n <= 1'b1;
      lnk.addr <= '0;
      lnk.dq_h <= 8'h00;
      lnk.dq_h_oe_n <= 1'b1;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      case (ph_q)
        FCD_IDLE: if (i_go) begin
          ph_q <= FCD_PHASE_A;
          cnt_q <= 4'h0;
          o_busy <= 1'b1;
          lnk.cs_n <= 1'b0;
          lnk.rw_n <= i_rd;
          lnk.addr <= i_addr;
          lnk.dq_h <= i_data;
          lnk.dq_h_oe_n <= i_rd;
        end
        FCD_PHASE_A: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'(LINK_DIV)) lnk.bus_clock <= 1'b1;
          if (cnt_q == 4'(2 * LINK_DIV)) begin
            lnk.bus_clock <= 1'b0;
            ph_q <= FCD_PHASE_B;
          end
        end
        FCD_PHASE_B: begin
          lnk.cs_n <= 1'b1;
          lnk.dq_h_oe_n <= 1'b1;
          o_busy <= 1'b0;
          ph_q <= FCD_IDLE;
        end
        default: ph_q <= FCD_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rvalid <= 1'b0;
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rvalid <= lnk.rvalid;
      if (lnk.rvalid) o_rdata <= lnk.dq_f;
    end
  end
endmodule
`default_nettype wire

// ===== tb/fcd_monitor.sv
// Link framing checks between host and flash ends
`timescale 1ns/100ps
`default_nettype none
module fcd_monitor (
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        cs_n,
  input wire logic        bus_clock,
  input wire logic        rw_n,
  input wire logic [23:0] addr,
  input wire logic [7:0]  dq_h,
  input wire logic        dq_h_oe_n,
  input wire logic        rvalid
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence start_s; $fell(cs_n); endsequence
  sequence rd_s; start_s ##0 rw_n; endsequence
  sequence wr_s; start_s ##0 !rw_n; endsequence
  clk_idle_a: assert property (cs_n |-> !bus_clock)
    else $error("link clock toggles outside a frame");
  frame_len_a: assert property (start_s |-> (!cs_n)[*8])
    else $error("frame shorter than expected");
  clk_rise_a: assert property (start_s |-> ##[1:12] $rose(bus_clock))
    else $error("no link clock edge in frame");
  frame_hold_a: assert property (!cs_n && $past(!cs_n) |->
    $stable(addr) && $stable(rw_n))
    else $error("address or direction moved in frame");
  wr_drive_a: assert property (!cs_n && !rw_n && bus_clock |->
    !dq_h_oe_n && $stable(dq_h))
    else $error("write data not driven at clock");
  rd_answer_a: assert property (rd_s |-> ##[3:14] rvalid)
    else $error("read frame got no answer");
  wr_quiet_a: assert property (wr_s |-> (!rvalid)[*8])
    else $error("answer in a write frame");
  one_word_a: assert property (rvalid |=> !rvalid)
    else $error("more than one answer word");
  rd_only_a: assert property (rvalid |-> !cs_n && rw_n && dq_h_oe_n)
    else $error("answer outside a read frame");
endmodule
`default_nettype wire

// ===== tb/flash_command_sequence_decoder_tb_top.sv
// Random and directed checks of both link ends
`timescale 1ns/100ps
`default_nettype none
module flash_command_sequence_decoder_tb_top;
  import fcd_pkg::*;
  logic        clk = 1'b0;
  logic        rst, go, rd, ers, fl, busy, rv, pg, sclr, esus, idm, eg;
  int          n_er = 0;
  logic [23:0] adr, loc, pa;
  logic [7:0]  dat, v;
  logic [15:0] arr, slk, rdata, pw, tmr, rdv;
  logic [5:0]  ps;
  int          seed = 18;
  int          n_fail = 0;
  int          checked = 0;
  int          n_clr = 0;
  int          n_pg = 0;
  logic [7:0]  ld [4] = '{C_TMR_LD, C_ICR_LD, C_ISR_LD, C_VCR_LD};
  logic [7:0]  rc [4] = '{C_TMR_RD, C_ICR_RD, C_ISR_RD, C_VCR_RD};
  logic [15:0] ex [4] = '{TMR_RST, ICR_RST, ISR_RST, VCR_RST};

  always #4 clk = ~clk;

  fcd_if u_fcd_if ();
  fcd_host u_fcd_host (.i_ref_clk(clk), .i_sys_rst(rst), .i_ce(1'b1),
    .lnk(u_fcd_if.host), .i_go(go), .i_rd(rd), .i_addr(adr),
    .i_data(dat), .o_busy(busy), .o_rvalid(rv), .o_rdata(rdata));
  fcd_flash u_fcd_flash (.i_ref_clk(clk), .i_sys_rst(rst), .i_ce(1'b1),
    .lnk(u_fcd_if.flash), .i_array_word(arr), .i_erasing(ers),
    .i_fail(fl), .i_sect_lock(slk), .o_loc(loc), .o_prog_word(pw),
    .o_prog_go(pg), .o_erase_go(eg), .o_param_sect(ps), .o_timer(tmr),
    .o_esus(esus), .o_psus(), .o_id_mode(idm), .o_sr_clr(sclr));
  fcd_monitor u_fcd_monitor (.i_ref_clk(clk), .i_sys_rst(rst),
    .cs_n(u_fcd_if.cs_n), .bus_clock(u_fcd_if.bus_clock),
    .rw_n(u_fcd_if.rw_n), .addr(u_fcd_if.addr), .dq_h(u_fcd_if.dq_h),
    .dq_h_oe_n(u_fcd_if.dq_h_oe_n), .rvalid(u_fcd_if.rvalid));

  // Pulses are counted so a missed or doubled one shows
  always @(posedge clk) begin
    if (sclr === 1'b1) n_clr++;
    if (pg === 1'b1) n_pg++;
    if (eg === 1'b1) n_er++;
  end

  task automatic chk(input string nm, input logic [23:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One frame; busy is read an edge late so the launch has landed
  task automatic cyc(input logic r, input logic [23:0] a,
                     input logic [7:0] d);
    int n;
    rdv = 'x;
    @(posedge clk);
    go  <= 1'b1;
    rd  <= r;
    adr <= a;
    dat <= d;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      @(posedge clk);
      if (rv === 1'b1) rdv = rdata;
      n++;
    end
    if (n >= 60) n_fail++;
  endtask

  function automatic logic [23:0] at(input logic [10:0] lo);
    return {13'($random(seed)), lo};
  endfunction

  task automatic cmd(input logic [7:0] c);
    cyc(1'b0, at(UNLOCK_A1), C_AA);
    cyc(1'b0, at(UNLOCK_A2), C_55);
    cyc(1'b0, at(UNLOCK_A1), c);
  endtask

  task automatic rd_array;
    arr <= 16'($random(seed));
    cyc(1'b1, 24'($random(seed)), 8'h00);
    chk("array", 24'(rdv), 24'(arr));
  endtask

  initial begin
    {go, rd, adr, dat, ers, fl, slk, arr} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 2; p++)
      for (int k = 0; k < 4; k++) begin
        if (p == 1) begin
          v = 8'($random(seed));
          cmd(ld[k]);
          cyc(1'b0, 24'($random(seed)), v);
          ex[k] = {v, v};
        end
        cmd(rc[k]);
        cyc(1'b1, 24'($random(seed)), 8'h00);
        chk("register", 24'(rdv), 24'(ex[k]));
      end
    chk("timer", 24'(tmr), 24'(ex[0]));
    cyc(1'b0, 24'h555, C_AA);
    cyc(1'b0, 24'h2aa, 8'h12);
    cyc(1'b0, 24'h555, C_TMR_LD);
    cyc(1'b0, 24'h000, 8'h5a);
    cmd(C_TMR_RD);
    cyc(1'b1, 24'h000, 8'h00);
    chk("dropped", 24'(rdv), 24'(ex[0]));
    rd_array();
    for (int f = 0; f < 2; f++) begin
      fl <= f[0];
      cyc(1'b0, 24'h555, C_SR_RD);
      cyc(1'b1, 24'($random(seed)), 8'h00);
      chk("status", 24'(rdv), f ? 24'hffff : 24'hffdf);
    end
    fl <= 1'b0;
    cyc(1'b0, 24'($random(seed)), C_EXIT);
    rd_array();
    cyc(1'b0, 24'h555, C_SR_CLR);
    chk("clear", 24'(n_clr), 24'h1);
    cmd(C_ID);
    chk("id", 24'(idm), 24'h1);
    slk <= 16'($random(seed));
    cyc(1'b1, at(11'h555), 8'h00);
    chk("lock", 24'(rdv), 24'({15'h7fff, slk[0]}));
    cyc(1'b0, 24'($random(seed)), C_EXIT);
    chk("id exit", 24'(idm), 24'h0);
    cyc(1'b0, 24'($random(seed)), C_ESUS);
    chk("idle suspend", 24'(esus), 24'h0);
    ers <= 1'b1;
    cyc(1'b0, 24'($random(seed)), C_ESUS);
    chk("suspend", 24'(esus), 24'h1);
    cmd(C_ID);
    chk("id in suspend", 24'(idm), 24'h1);
    cyc(1'b0, 24'($random(seed)), C_EXIT);
    cyc(1'b0, 24'($random(seed)), C_ERES);
    chk("resume", 24'(esus), 24'h0);
    ers <= 1'b0;
    pa = 24'($random(seed));
    v = 8'($random(seed));
    cmd(C_PROG);
    cyc(1'b0, pa, v);
    chk("program go", 24'(n_pg), 24'h1);
    chk("location", loc, pa);
    chk("word", 24'(pw[7:0]), 24'(v));
    chk("param sector", 24'(ps), 24'(pa[16:11]));
    pa = 24'($random(seed));
    cmd(C_ERS1);
    cyc(1'b0, at(UNLOCK_A1), C_AA);
    cyc(1'b0, at(UNLOCK_A2), C_55);
    cyc(1'b0, pa, C_SECT);
    chk("erase go", 24'(n_er), 24'h1);
    chk("erase sector", 24'(ps), 24'(pa[16:11]));
    complete_run();
  end

  // Roughly ten times the expected run
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
